//--- core/sfwp_pkg.sv
// Function
// - Page write, quad page write and info row write need the latch set.
// - Sector, both block and whole array clears need the write latch set.
// - Register writes need the latch; any write without it is ignored.
// - Program or erase aimed at a protected area is inhibited.
// - Whole array clear is ignored unless all four protect bits are zero.
// - Lockout bit one with write-protect pin low blocks status writes; the code blocks them only while lane select is zero.
// - Status writes pass if lockout is zero or write-protect pin is high.
// - Four lane select zero gives protect and hold pins; one gives data lanes.
// - 4Mb protect codes map onto eight 64K blocks as tabled.
// - Smaller densities use their own reduced protect code tables.
// - Suspend during program sets program suspended flag; resume clears it.
// - Suspend during erase sets erase suspended flag; resume clears it.
// - Info row lock bits are one-time programmable; never return to zero; the code clears them to LOCK_RST at reset.
// - A set info row lock refuses programming of that row.
// - Function bits zero and one read as zero; suspend flags are read-only.
// - Latch set by enable, cleared by disable and by any completed write.
// - Status: protect 2-5, lane select 6, lockout 7; only status write sets.
package sfwp_pkg;

	// ----------------------------------------------------------------
	// Link capture geometry
	// ----------------------------------------------------------------
	localparam int CNT_W  = 12;
	localparam int HEAD_W = 40;
	localparam logic [CNT_W-1:0] CNT_ONE  = 12'h001;
	localparam logic [CNT_W-1:0] LEN_OPC  = 12'h008;
	localparam logic [CNT_W-1:0] LEN_REG  = 12'h010;
	localparam logic [CNT_W-1:0] LEN_ADDR = 12'h020;
	localparam logic [CNT_W-1:0] LEN_HEAD = 12'h028;

	// ----------------------------------------------------------------
	// Instruction codes
	// ----------------------------------------------------------------
	localparam logic [7:0] OPC_WRITE_ENABLE   = 8'h06;
	localparam logic [7:0] OPC_WRITE_DISABLE  = 8'h04;
	localparam logic [7:0] OPC_PAGE_WRITE     = 8'h02;
	localparam logic [7:0] OPC_PAGE_QUAD_A    = 8'h32;
	localparam logic [7:0] OPC_PAGE_QUAD_B    = 8'h38;
	localparam logic [7:0] OPC_SECTOR_CLR_A   = 8'hd7;
	localparam logic [7:0] OPC_SECTOR_CLR_B   = 8'h20;
	localparam logic [7:0] OPC_BLOCK_CLR_SM   = 8'h52;
	localparam logic [7:0] OPC_BLOCK_CLR_LG   = 8'hd8;
	localparam logic [7:0] OPC_WHOLE_CLR_A    = 8'hc7;
	localparam logic [7:0] OPC_WHOLE_CLR_B    = 8'h60;
	localparam logic [7:0] OPC_STATUS_WRITE   = 8'h01;
	localparam logic [7:0] OPC_FUNCTION_WRITE = 8'h42;
	localparam logic [7:0] OPC_INFO_ROW_WRITE = 8'h62;
	localparam logic [7:0] OPC_SUSPEND_A      = 8'h75;
	localparam logic [7:0] OPC_SUSPEND_B      = 8'hb0;
	localparam logic [7:0] OPC_RESUME_A       = 8'h7a;
	localparam logic [7:0] OPC_RESUME_B       = 8'h30;

	// ----------------------------------------------------------------
	// Register layout and reset values
	// ----------------------------------------------------------------
	localparam int ST_BUSY    = 0;
	localparam int ST_WLATCH  = 1;
	localparam int ST_PROT_LO = 2;
	localparam int ST_LANES   = 6;
	localparam int ST_LOCKOUT = 7;
	localparam int FN_PSUSP   = 2;
	localparam int FN_ESUSP   = 3;
	localparam int FN_LOCK_LO = 4;
	localparam logic [3:0] PROT_RST = 4'h0;
	localparam logic [3:0] LOCK_RST = 4'h0;
	localparam logic [1:0] FN_RSVD  = 2'h0;
	localparam int ROW_LO = 8;
	localparam int BLK_LO = 16;

	// ----------------------------------------------------------------
	// Densities and erase kinds
	// ----------------------------------------------------------------
	localparam logic [1:0] DENS_4M    = 2'h0;
	localparam logic [1:0] DENS_2M    = 2'h1;
	localparam logic [1:0] DENS_1M    = 2'h2;
	localparam logic [1:0] DENS_SMALL = 2'h3;
	localparam logic [1:0] EK_SECTOR  = 2'h0;
	localparam logic [1:0] EK_SMALL   = 2'h1;
	localparam logic [1:0] EK_LARGE   = 2'h2;
	localparam logic [1:0] EK_CHIP    = 2'h3;

endpackage

//--- core/sfwp_link_cap.sv
`timescale 1ns/1ps
module sfwp_link_cap
	import sfwp_pkg::*;
(
	// Link clock and serial data
	input  wire logic              sck_i,
	input  wire logic              si_i,
	// System reset, crossed here
	input  wire logic              nrst_i,
	// Count at the start of this frame
	input  wire logic [CNT_W-1:0]  base_i,
	// Captured frame
	output logic      [CNT_W-1:0]  cnt_o,
	output logic      [HEAD_W-1:0] head_o
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic              rst_s1;
		logic              rst_s2;
		logic [CNT_W-1:0]  cnt;
		logic [HEAD_W-1:0] head;
	} sfwp_link_t;

	sfwp_link_t       st_reg;
	sfwp_link_t       st_next;
	logic [CNT_W-1:0] idx;

	// Bit index within the current frame
	assign idx = st_reg.cnt - base_i;

	// Free-running bit count, head keeps first forty bits
	always_comb
	begin
		st_next        = st_reg;
		st_next.rst_s1 = nrst_i;
		st_next.rst_s2 = st_reg.rst_s1;
		if (!st_reg.rst_s2)
		begin
			st_next.cnt  = '0;
			st_next.head = '0;
		end
		else
		begin
			st_next.cnt = st_reg.cnt + CNT_ONE;
			if (idx < LEN_HEAD)
			begin
				st_next.head = {st_reg.head[HEAD_W-2:0], si_i};
			end
		end
	end

	// Register on the link clock
	always_ff @(posedge sck_i)
	begin
		st_reg <= st_next;
	end

	// Outputs
	assign cnt_o  = st_reg.cnt;
	assign head_o = st_reg.head;

endmodule

//--- core/sfwp_core.sv
`timescale 1ns/1ps
module sfwp_core
	import sfwp_pkg::*;
#(
	parameter logic [1:0] DENSITY = DENS_4M
)
(
	// System clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        nrst_i,
	// Serial link
	input  wire logic        sck_i,
	input  wire logic        cs_n_i,
	input  wire logic        si_i,
	// Protect and hold pins
	input  wire logic        wp_n_i,
	input  wire logic        hold_n_i,
	// Array engine
	input  wire logic        op_done_i,
	output logic             prog_start_o,
	output logic             erase_start_o,
	output logic             suspend_o,
	output logic             resume_o,
	output logic      [23:0] op_addr_o,
	output logic      [1:0]  erase_kind_o,
	output logic             info_row_o,
	// Register images
	output logic      [7:0]  status_o,
	output logic      [7:0]  function_o,
	// Pin functions
	output logic             wp_func_o,
	output logic             hold_func_o,
	output logic             quad_lanes_o,
	output logic             hold_active_o
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_IDLE = 3'b001,
		OP_RUN  = 3'b010,
		OP_SUSP = 3'b100
	} sfwp_op_t;

	typedef struct packed {
		logic             cs_s1;
		logic             cs_s2;
		logic             cs_s3;
		logic             wp_s1;
		logic             wp_s2;
		logic             hold_s1;
		logic             hold_s2;
		logic [CNT_W-1:0] base;
		logic             wlatch;
		logic [3:0]       prot;
		logic             lanes;
		logic             lockout;
		logic [3:0]       lock;
		logic             psusp;
		logic             esusp;
		sfwp_op_t         op;
		logic             op_erase;
		logic             prog_start;
		logic             erase_start;
		logic             suspend;
		logic             resume;
		logic [23:0]      addr;
		logic [1:0]       ekind;
		logic             info_row;
		logic             pin_fn;
		logic             hold_act;
	} sfwp_sys_t;

	sfwp_sys_t         st_reg;
	sfwp_sys_t         st_next;
	logic [CNT_W-1:0]  link_cnt;
	logic [HEAD_W-1:0] link_head;
	logic              frame_end;
	logic [CNT_W-1:0]  nbits;
	logic [HEAD_W-1:0] al;
	logic [7:0]        opc;
	logic [23:0]       taddr;
	logic [7:0]        dbyte;
	logic              byte_ok;
	logic              can_write;
	logic              sr_locked;
	logic              tgt_prot;
	logic              row_locked;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Protected block mask per code and density
	function automatic logic [7:0] prot_mask(input logic [3:0] bp,
		input logic [1:0] dens);
		logic [7:0] m;
		m = 8'hff;
		if (bp == 4'h0 || bp == 4'hf)
		begin
			m = 8'h00;
		end
		else
		begin
			unique case (dens)
				DENS_4M:
				begin
					case (bp)
						4'h1: m = 8'h80;
						4'h2: m = 8'hc0;
						4'h3: m = 8'hf0;
						4'hc: m = 8'h0f;
						4'hd: m = 8'h03;
						4'he: m = 8'h01;
						default: m = 8'hff;
					endcase
				end
				DENS_2M:
				begin
					case (bp)
						4'h1: m = 8'h08;
						4'h2: m = 8'h0c;
						4'hd: m = 8'h03;
						4'he: m = 8'h01;
						default: m = 8'hff;
					endcase
				end
				DENS_1M:
				begin
					case (bp)
						4'h1: m = 8'h02;
						4'he: m = 8'h01;
						default: m = 8'hff;
					endcase
				end
				DENS_SMALL: m = 8'hff;
			endcase
		end
		return m;
	endfunction

	// Target block protected under given code
	function automatic logic blk_prot(input logic [3:0] bp,
		input logic [23:0] a);
		logic [7:0] m;
		logic [2:0] b;
		m = prot_mask(bp, DENSITY);
		unique case (DENSITY)
			DENS_4M:    b = a[BLK_LO+:3];
			DENS_2M:    b = {1'b0, a[BLK_LO+:2]};
			DENS_1M:    b = {2'b00, a[BLK_LO]};
			DENS_SMALL: b = 3'h0;
		endcase
		return m[b];
	endfunction

	// Left-justify a short frame into the head window
	function automatic logic [HEAD_W-1:0] align_head(
		input logic [HEAD_W-1:0] h, input logic [CNT_W-1:0] n);
		if (n >= LEN_HEAD)
		begin
			return h;
		end
		return h << (LEN_HEAD - n);
	endfunction

	// ----------------------------------------------------------------
	// Link side capture
	// ----------------------------------------------------------------
	sfwp_link_cap u_link (
		.sck_i  (sck_i),
		.si_i   (si_i),
		.nrst_i (nrst_i),
		.base_i (st_reg.base),
		.cnt_o  (link_cnt),
		.head_o (link_head)
	);

	// ----------------------------------------------------------------
	// Frame decode
	// ----------------------------------------------------------------
	// Frame ends on synchronised chip select rising
	assign frame_end = st_reg.cs_s2 & ~st_reg.cs_s3;
	assign nbits     = link_cnt - st_reg.base;
	assign al        = align_head(link_head, nbits);
	assign opc       = al[39:32];
	assign taddr     = al[31:8];
	assign dbyte     = al[31:24];
	assign byte_ok   = (nbits[2:0] == 3'h0);

	// Write gating and protection, judged on captured frame
	assign can_write  = st_reg.wlatch & (st_reg.op == OP_IDLE);
	assign sr_locked  = st_reg.lockout & ~st_reg.wp_s2 & st_reg.pin_fn;
	assign tgt_prot   = blk_prot(st_reg.prot, taddr);
	assign row_locked = st_reg.lock[taddr[ROW_LO+:2]];

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		st_next             = st_reg;
		st_next.cs_s1       = cs_n_i;
		st_next.cs_s2       = st_reg.cs_s1;
		st_next.cs_s3       = st_reg.cs_s2;
		st_next.wp_s1       = wp_n_i;
		st_next.wp_s2       = st_reg.wp_s1;
		st_next.hold_s1     = hold_n_i;
		st_next.hold_s2     = st_reg.hold_s1;
		st_next.prog_start  = 1'b0;
		st_next.erase_start = 1'b0;
		st_next.suspend     = 1'b0;
		st_next.resume      = 1'b0;

		// Completed write drops the latch
		if (st_reg.op == OP_RUN && op_done_i)
		begin
			st_next.op     = OP_IDLE;
			st_next.wlatch = 1'b0;
		end

		if (frame_end)
		begin
			st_next.base = link_cnt;
			if (byte_ok && nbits >= LEN_OPC)
			begin
				case (opc)
					OPC_WRITE_ENABLE:  st_next.wlatch = 1'b1;
					OPC_WRITE_DISABLE: st_next.wlatch = 1'b0;
					OPC_STATUS_WRITE:
					begin
						// Passes unless locked out by pin
						if (can_write && nbits >= LEN_REG && !sr_locked)
						begin
							st_next.prot    = dbyte[ST_PROT_LO+:4];
							st_next.lanes   = dbyte[ST_LANES];
							st_next.lockout = dbyte[ST_LOCKOUT];
							st_next.wlatch  = 1'b0;
						end
					end
					OPC_FUNCTION_WRITE:
					begin
						if (can_write && nbits >= LEN_REG)
						begin
							// Locks only ever set
							st_next.lock   = st_reg.lock |
								dbyte[FN_LOCK_LO+:4];
							st_next.wlatch = 1'b0;
						end
					end
					OPC_PAGE_WRITE, OPC_PAGE_QUAD_A, OPC_PAGE_QUAD_B,
					OPC_INFO_ROW_WRITE:
					begin
						if (can_write && nbits >= LEN_HEAD)
						begin
							if (opc == OPC_INFO_ROW_WRITE ? !row_locked
								: !tgt_prot)
							begin
								st_next.op         = OP_RUN;
								st_next.op_erase   = 1'b0;
								st_next.prog_start = 1'b1;
								st_next.addr       = taddr;
								st_next.info_row   =
									(opc == OPC_INFO_ROW_WRITE);
							end
						end
					end
					OPC_SECTOR_CLR_A, OPC_SECTOR_CLR_B, OPC_BLOCK_CLR_SM,
					OPC_BLOCK_CLR_LG:
					begin
						if (can_write && nbits >= LEN_ADDR && !tgt_prot)
						begin
							st_next.op          = OP_RUN;
							st_next.op_erase    = 1'b1;
							st_next.erase_start = 1'b1;
							st_next.addr        = taddr;
							st_next.info_row    = 1'b0;
							st_next.ekind       =
								(opc == OPC_BLOCK_CLR_SM) ? EK_SMALL :
								(opc == OPC_BLOCK_CLR_LG) ? EK_LARGE :
								EK_SECTOR;
						end
					end
					OPC_WHOLE_CLR_A, OPC_WHOLE_CLR_B:
					begin
						if (can_write && st_reg.prot == PROT_RST)
						begin
							st_next.op          = OP_RUN;
							st_next.op_erase    = 1'b1;
							st_next.erase_start = 1'b1;
							st_next.addr        = '0;
							st_next.info_row    = 1'b0;
							st_next.ekind       = EK_CHIP;
						end
					end
					OPC_SUSPEND_A, OPC_SUSPEND_B:
					begin
						if (st_next.op == OP_RUN)
						begin
							st_next.op      = OP_SUSP;
							st_next.suspend = 1'b1;
							st_next.psusp   = ~st_reg.op_erase;
							st_next.esusp   = st_reg.op_erase;
						end
					end
					OPC_RESUME_A, OPC_RESUME_B:
					begin
						if (st_reg.op == OP_SUSP)
						begin
							st_next.op     = OP_RUN;
							st_next.resume = 1'b1;
							st_next.psusp  = 1'b0;
							st_next.esusp  = 1'b0;
						end
					end
					default: st_next.op = st_next.op;
				endcase
			end
		end

		// Pin functions follow lane select
		st_next.pin_fn   = ~st_next.lanes;
		st_next.hold_act = st_next.pin_fn & ~st_reg.hold_s2;

		if (!nrst_i)
		begin
			st_next         = '0;
			st_next.cs_s1   = 1'b1; // Pin idle level, no false edge
			st_next.cs_s2   = 1'b1;
			st_next.cs_s3   = 1'b1;
			st_next.wp_s1   = 1'b1;
			st_next.wp_s2   = 1'b1;
			st_next.hold_s1 = 1'b1; // No false hold after reset
			st_next.hold_s2 = 1'b1;
			st_next.op    = OP_IDLE;
			st_next.prot  = PROT_RST;
			st_next.lock  = LOCK_RST;
			st_next.pin_fn = 1'b1;
		end
	end

	// Register on the system clock
	always_ff @(posedge clk_sys_i)
	begin
		st_reg <= st_next;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign prog_start_o  = st_reg.prog_start;
	assign erase_start_o = st_reg.erase_start;
	assign suspend_o     = st_reg.suspend;
	assign resume_o      = st_reg.resume;
	assign op_addr_o     = st_reg.addr;
	assign erase_kind_o  = st_reg.ekind;
	assign info_row_o    = st_reg.info_row;
	assign status_o      = {st_reg.lockout, st_reg.lanes, st_reg.prot,
		st_reg.wlatch, st_reg.op[1]};
	assign function_o    = {st_reg.lock, st_reg.esusp, st_reg.psusp,
		FN_RSVD};
	assign wp_func_o     = st_reg.pin_fn;
	assign hold_func_o   = st_reg.pin_fn;
	assign quad_lanes_o  = st_reg.lanes;
	assign hold_active_o = st_reg.hold_act;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!nrst_i);

	AST_PROG_LATCH: assert property (
		prog_start_o |-> status_o[ST_WLATCH] && status_o[ST_BUSY])
		else $error("program started without write latch");
	AST_ERASE_LATCH: assert property (
		erase_start_o |-> status_o[ST_WLATCH] && status_o[ST_BUSY])
		else $error("erase started without write latch");
	AST_REG_LATCH: assert property (
		$changed(function_o[7:4]) |-> $past(status_o[ST_WLATCH])
		&& !status_o[ST_WLATCH])
		else $error("function write without write latch");
	AST_PROT_BLOCK: assert property (
		(prog_start_o && !info_row_o) || (erase_start_o
		&& erase_kind_o != EK_CHIP) |-> !blk_prot(status_o[5:2], op_addr_o))
		else $error("write started in protected block");
	AST_CHIP_CLEAR: assert property (
		erase_start_o && erase_kind_o == EK_CHIP |-> status_o[5:2] == PROT_RST)
		else $error("whole array clear with protect bits set");
	AST_SR_LOCK: assert property (
		$changed(status_o[7:2]) |-> !($past(status_o[ST_LOCKOUT])
		&& !$past(st_reg.wp_s2) && $past(wp_func_o)))
		else $error("status changed while hardware locked");
	AST_PIN_FN: assert property (
		quad_lanes_o |-> !wp_func_o && !hold_func_o && !hold_active_o)
		else $error("protect or hold pin active with four lanes");
	AST_LOCK_OTP: assert property (
		(function_o[7:4] & $past(function_o[7:4])) == $past(function_o[7:4]))
		else $error("info row lock returned to zero");
	AST_ROW_LOCK: assert property (
		prog_start_o && info_row_o |-> !function_o[FN_LOCK_LO
		+ op_addr_o[ROW_LO+:2]])
		else $error("locked info row programmed");
	AST_PSUSP: assert property (
		$rose(function_o[FN_PSUSP]) |-> suspend_o && !$past(st_reg.op_erase))
		else $error("program suspended flag without suspend");
	AST_ESUSP: assert property (
		$fell(function_o[FN_ESUSP]) |-> resume_o && status_o[ST_BUSY])
		else $error("erase suspended flag cleared without resume");
	AST_RSVD: assert property (
		function_o[1:0] == FN_RSVD)
		else $error("reserved function bits not zero");
	AST_DONE_LATCH: assert property (
		status_o[ST_BUSY] && op_done_i |=> !status_o[ST_WLATCH])
		else $error("write latch kept after completion");

endmodule

//--- sim/sfwp_host.sv
`timescale 1ns/1ps
module sfwp_host
(
	// Serial link towards the device
	output logic sck_o,
	output logic cs_n_o,
	output logic si_o
);
	// ----------------------------------------------------------------
	// Idle levels: clock low, deselected
	// ----------------------------------------------------------------
	initial
	begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		si_o = 1'b0;
	end

	// Free link edges, only around reset
	task automatic warm(input int n);
		repeat (n)
		begin
			#15 sck_o = 1'b1;
			#15 sck_o = 1'b0;
		end
	endtask

	// One frame, mode 0, MSB first; gap sets prompt or slow
	task automatic frame(input logic [39:0] d, input int nb, input int gap);
		int i;
		cs_n_o = 1'b0;
		#(gap);
		for (i = 8 * nb - 1; i >= 0; i--)
		begin
			si_o = d[i];
			#15 sck_o = 1'b1;
			#15 sck_o = 1'b0;
		end
		#(gap);
		cs_n_o = 1'b1;
		si_o = ~si_o; // Released line shows no stale bit
	endtask
endmodule

//--- sim/tb_top.sv
`timescale 1ns/1ps
module tb_top
	import sfwp_pkg::*;
;
	logic        clk_sys_i = 1'b0;
	logic        nrst_i, wp_n_i, hold_n_i, op_done_i;
	logic        sck, cs_n, si;
	logic        prog_start_o, erase_start_o, suspend_o, resume_o;
	logic        info_row_o, wp_func_o, hold_func_o, quad_lanes_o;
	logic        hold_active_o, erase2;
	logic [23:0] op_addr_o, addr;
	logic [1:0]  erase_kind_o;
	logic [7:0]  status_o, function_o;
	logic [31:0] seed = 32'h05cd3607;
	logic [39:0] d;
	int          err_total, n_compared, cyc, i, c;
	int          n_prog, n_erase, n_erase2, n_susp, n_res, e0, f0;
	logic [7:0]  opc [10] = '{8'h20, 8'hd7, 8'h52, 8'hd8, 8'hc7, 8'h60,
		8'h02, 8'h32, 8'h38, 8'h62};
	logic [1:0]  kind [6] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h3};

	// ----------------------------------------------------------------
	// Clock, partner and devices (4Mb and 2Mb tables)
	// ----------------------------------------------------------------
	always #4 clk_sys_i = ~clk_sys_i;

	sfwp_host host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si));

	sfwp_core dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .sck_i(sck),
		.cs_n_i(cs_n), .si_i(si), .wp_n_i(wp_n_i), .hold_n_i(hold_n_i),
		.op_done_i(op_done_i), .prog_start_o(prog_start_o),
		.erase_start_o(erase_start_o), .suspend_o(suspend_o),
		.resume_o(resume_o), .op_addr_o(op_addr_o),
		.erase_kind_o(erase_kind_o), .info_row_o(info_row_o),
		.status_o(status_o), .function_o(function_o),
		.wp_func_o(wp_func_o), .hold_func_o(hold_func_o),
		.quad_lanes_o(quad_lanes_o), .hold_active_o(hold_active_o));

	sfwp_core #(.DENSITY(DENS_2M)) dut2 (.clk_sys_i(clk_sys_i),
		.nrst_i(nrst_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
		.wp_n_i(wp_n_i), .hold_n_i(hold_n_i), .op_done_i(op_done_i),
		.prog_start_o(), .erase_start_o(erase2), .suspend_o(),
		.resume_o(), .op_addr_o(), .erase_kind_o(), .info_row_o(),
		.status_o(), .function_o(), .wp_func_o(), .hold_func_o(),
		.quad_lanes_o(), .hold_active_o());

	// Pulse counters and hang limit
	always @(posedge clk_sys_i)
	begin
		n_prog += (prog_start_o === 1'b1);
		n_erase += (erase_start_o === 1'b1);
		n_erase2 += (erase2 === 1'b1);
		n_susp += (suspend_o === 1'b1);
		n_res += (resume_o === 1'b1);
		cyc++;
		if (cyc > 60000)
		begin
			err_total++;
			conclude();
		end
	end

	// ----------------------------------------------------------------
	// Expectations and helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic prot4(input logic [3:0] p, input logic [2:0] b);
		case (p)
			4'h0, 4'hf: return 1'b0;
			4'h1: return b == 3'h7;
			4'h2: return b >= 3'h6;
			4'h3: return b >= 3'h4;
			4'hc: return b <= 3'h3;
			4'hd: return b <= 3'h1;
			4'he: return b == 3'h0;
			default: return 1'b1;
		endcase
	endfunction

	function automatic logic prot2(input logic [3:0] p, input logic [1:0] b);
		case (p)
			4'h0, 4'hf: return 1'b0;
			4'h1: return b == 2'h3;
			4'h2: return b >= 2'h2;
			4'hd: return b <= 2'h1;
			4'he: return b == 2'h0;
			default: return 1'b1;
		endcase
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Frame with random pacing, then wait for the decode
	task automatic sendf(input logic [39:0] v, input int nb);
		@(posedge clk_sys_i);
		#1;
		seed = lfsr(seed);
		host.frame(v, nb, 5 + 10 * seed[20:18]);
		repeat (8) @(posedge clk_sys_i);
		#1;
	endtask

	task automatic write_enable_instruction();
		sendf(40'h06, 1);
	endtask

	task automatic wsr(input logic [7:0] v);
		write_enable_instruction();
		sendf({24'h0, 8'h01, v}, 2);
	endtask

	// Array engine completion pulse
	task automatic done();
		@(posedge clk_sys_i);
		#1 op_done_i = 1'b1;
		@(posedge clk_sys_i);
		#1 op_done_i = 1'b0;
		repeat (2) @(posedge clk_sys_i);
		#1;
	endtask

	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		nrst_i = 1'b0;
		wp_n_i = 1'b1;
		hold_n_i = 1'b1;
		op_done_i = 1'b0;
		// Three link edges in reset, two after; then the link clock rests
		fork
			host.warm(5);
		join_none
		repeat (12) @(posedge clk_sys_i);
		#1 nrst_i = 1'b1;
		repeat (20) @(posedge clk_sys_i);
		#1;
		chk(status_o, 8'h00);
		chk(function_o, 8'h00);
		chk({wp_func_o, hold_func_o, quad_lanes_o}, 3'h6);
		// Writes without the latch are dropped
		sendf({8'h02, 24'h001000, 8'h5a}, 5);
		sendf({24'h0, 8'h01, 8'h3c}, 2);
		chk({n_prog[23:0], status_o}, 32'h0);
		write_enable_instruction();
		chk(status_o, 8'h02);
		sendf(40'h04, 1);
		chk(status_o, 8'h00);
		// Every protect code against a random block
		for (c = 0; c < 16; c++)
		begin
			wsr({2'h0, c[3:0], 2'h0});
			chk(status_o, {2'h0, c[3:0], 2'h0});
			seed = lfsr(seed);
			addr = {5'h0, seed[2:0], seed[15:0]};
			e0 = n_erase;
			f0 = n_erase2;
			write_enable_instruction();
			sendf({8'h0, seed[16] ? 8'h20 : 8'hd7, addr}, 4);
			chk(n_erase - e0, !prot4(c[3:0], addr[18:16]));
			chk(n_erase2 - f0, !prot2(c[3:0], addr[17:16]));
			done();
		end
		e0 = n_erase;
		write_enable_instruction();
		sendf({8'h0, 8'hc7, 24'h0}, 4);
		chk(n_erase - e0, 0);
		wsr(8'h00);
		// Every program and erase opcode with no protection
		for (i = 0; i < 10; i++)
		begin
			seed = lfsr(seed);
			addr = {5'h0, seed[18:0]};
			e0 = n_erase + n_prog;
			write_enable_instruction();
			if (i < 6)
				sendf({8'h0, opc[i], addr}, 4);
			else
				sendf({opc[i], addr, seed[26:19]}, 5);
			chk(n_erase + n_prog - e0, 1);
			chk(status_o[0], 1'b1);
			if (i < 6)
				chk({erase_kind_o, op_addr_o}, {kind[i], i < 4 ? addr : 24'h0});
			else
				chk({info_row_o, op_addr_o}, {i == 9, addr});
			done();
			chk(status_o[1:0], 2'h0);
		end
		// Status lockout against the protect pin
		wsr(8'h80);
		wp_n_i = 1'b0;
		wsr(8'h04);
		chk(status_o, 8'h82);
		wp_n_i = 1'b1;
		wsr(8'h04);
		chk(status_o, 8'h04);
		wp_n_i = 1'b0;
		hold_n_i = 1'b0;
		wsr(8'h40);
		chk(status_o, 8'h40);
		chk({wp_func_o, hold_func_o, quad_lanes_o, hold_active_o}, 4'h2);
		wsr(8'h00);
		chk({wp_func_o, hold_func_o, quad_lanes_o, hold_active_o}, 4'hd);
		wp_n_i = 1'b1;
		hold_n_i = 1'b1;
		// Suspend and resume of program, then of erase
		for (i = 0; i < 2; i++)
		begin
			e0 = n_susp;
			f0 = n_res;
			write_enable_instruction();
			if (i == 0)
				sendf({8'h02, 24'h020000, 8'h11}, 5);
			else
				sendf({8'h0, 8'h20, 24'h020000}, 4);
			sendf(i == 0 ? 40'h75 : 40'hb0, 1);
			chk(n_susp - e0, 1);
			chk(status_o[0], 1'b0);
			chk(function_o, i == 0 ? 8'h04 : 8'h08);
			sendf(i == 0 ? 40'h7a : 40'h30, 1);
			chk(n_res - f0, 1);
			chk(status_o[0], 1'b1);
			chk(function_o, 8'h00);
			done();
		end
		// Lock bits one way only, reserved and flags read-only
		write_enable_instruction();
		sendf({24'h0, 8'h42, 8'h1f}, 2);
		chk(function_o, 8'h10);
		write_enable_instruction();
		sendf({24'h0, 8'h42, 8'h00}, 2);
		chk(function_o, 8'h10);
		e0 = n_prog;
		write_enable_instruction();
		sendf({8'h62, 24'h000000, 8'h77}, 5);
		chk(n_prog - e0, 0);
		write_enable_instruction();
		sendf({8'h62, 24'h000100, 8'h77}, 5);
		chk(n_prog - e0, 1);
		done();
		conclude();
	end
endmodule
